/* File: verilog/modbus_slave_pkg.sv */
// Constants and types shared by the Modbus RTU slave command handler
`default_nettype none
package modbus_slave_pkg;
  // ************************************************************
  // Function and exception codes
  // ************************************************************
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_BUSY = 8'h06;
  localparam logic [7:0] EXC_NAK = 8'h07;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam int NUM_CHANNELS = 7;
  localparam logic [15:0] CHAN_FIRST_ADDR = 16'h9c71;
  localparam logic [15:0] CHAN_LAST_ADDR = 16'h9c77;
  localparam logic [15:0] CFG_WREN_ADDR = 16'h0000;
  localparam logic [15:0] CFG_CHEN_ADDR = 16'h0001;
  localparam logic [15:0] CHEN_MAX_VALUE = 16'h007f;
  localparam logic [15:0] WREN_MAX_VALUE = 16'h0001;
  localparam logic [6:0] CHEN_RESET = 7'h7f;
  localparam logic WREN_RESET = 1'b0;
  localparam logic [15:0] READ_MAX_QTY = 16'h007d;
  localparam logic [15:0] WRITE_MAX_QTY = 16'h0002;
  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int BUF_DEPTH = 256;
  localparam int IDX_SLAVE = 0;
  localparam int IDX_FUNC = 1;
  localparam int IDX_ADDR_HI = 2;
  localparam int IDX_ADDR_LO = 3;
  localparam int IDX_QTY_HI = 4;
  localparam int IDX_QTY_LO = 5;
  localparam int IDX_BCOUNT = 6;
  localparam int IDX_WDATA = 7;
  localparam logic [8:0] MIN_FRAME_LEN = 9'h004;
  localparam logic [8:0] READ_FRAME_LEN = 9'h008;
  localparam logic [8:0] WRITE_HDR_LEN = 9'h009;
  localparam logic [8:0] READ_REPLY_FIXED = 9'h005;
  localparam logic [8:0] WRITE_REPLY_LEN = 9'h008;
  localparam logic [8:0] EXC_REPLY_LEN = 9'h005;
  localparam logic [8:0] READ_DATA_START = 9'h003;
  localparam logic [8:0] ECHO_BYTES = 9'h006;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int BUSY_TIME_S = 3;
  localparam int unsigned BUSY_CYCLES_DEFAULT =
    32'(64'(BUSY_TIME_S) * 64'd1000000000 / 64'(CLK_PERIOD_NS));
  typedef enum {kind_read, kind_write, kind_exc} reply_kind_t;
endpackage
`default_nettype wire

/* File: verilog/modbus_slave.sv */
// Modbus RTU slave: read/preset-multiple handler with exception replies
`default_nettype none
module modbus_slave #(
  parameter int unsigned BUSY_CYCLES = modbus_slave_pkg::BUSY_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] slave_addr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic tx_ready,
  input wire logic [15:0] chan_result [modbus_slave_pkg::NUM_CHANNELS],
  input wire logic [6:0] nv_chen,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic nv_wr,
  output logic [6:0] nv_data,
  output logic [6:0] chan_enable,
  output logic busy
);
  import modbus_slave_pkg::*;

  typedef enum {st_rx, st_check, st_tx} state_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ************************************************************
  // Power-up busy window
  // ************************************************************
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  logic next_busy;

  always_comb
  begin
    next_busy_cnt = busy_cnt;
    next_busy = busy;
    if (busy)
    begin
      next_busy_cnt = busy_cnt + 32'h00000001;
      if (busy_cnt == BUSY_CYCLES - 1)
        next_busy = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_cnt <= 32'h00000000;
      busy <= 1'b1;
    end
    else
    begin
      busy_cnt <= next_busy_cnt;
      busy <= next_busy;
    end
  end

  // ************************************************************
  // Frame buffer and decode
  // ************************************************************
  // Received bytes stay put during the reply, so the echo reads them back
  logic [7:0] frame_buf [BUF_DEPTH];
  state_t st;
  state_t next_st;
  logic [8:0] rx_cnt;
  logic [8:0] next_rx_cnt;
  logic [15:0] rx_crc;
  logic [15:0] next_rx_crc;
  logic rx_ovf;
  logic next_rx_ovf;

  always_ff @(posedge clk)
  begin
    if (st == st_rx && rx_valid && !rx_cnt[8])
      frame_buf[rx_cnt[7:0]] <= rx_data;
  end

  logic [7:0] func;
  logic [15:0] start;
  logic [15:0] qty;
  logic [7:0] bcount;
  logic [15:0] wval0;
  logic [15:0] wval1;
  logic [16:0] last_addr;
  logic good_frame;
  logic is_read;
  logic in_chan;
  logic in_cfg;
  logic hit_wren;
  logic hit_chen;
  logic [15:0] chen_val;

  always_comb
  begin
    func = frame_buf[IDX_FUNC];
    start = {frame_buf[IDX_ADDR_HI], frame_buf[IDX_ADDR_LO]};
    qty = {frame_buf[IDX_QTY_HI], frame_buf[IDX_QTY_LO]};
    bcount = frame_buf[IDX_BCOUNT];
    wval0 = {frame_buf[IDX_WDATA], frame_buf[IDX_WDATA + 1]};
    wval1 = {frame_buf[IDX_WDATA + 2], frame_buf[IDX_WDATA + 3]};
    last_addr = {1'b0, start} + {1'b0, qty} - 17'h00001;
    // Bad CRC or foreign address: silently dropped, as RTU slaves must
    good_frame = rx_cnt >= MIN_FRAME_LEN && rx_crc == 16'h0000 && !rx_ovf
      && frame_buf[IDX_SLAVE] == slave_addr;
    is_read = func == FC_READ_HOLD || func == FC_READ_INPUT;
    in_chan = start >= CHAN_FIRST_ADDR && last_addr <= {1'b0, CHAN_LAST_ADDR};
    in_cfg = last_addr <= {1'b0, CFG_CHEN_ADDR};
    hit_wren = start == CFG_WREN_ADDR;
    hit_chen = start == CFG_CHEN_ADDR || qty == WRITE_MAX_QTY;
    chen_val = (start == CFG_CHEN_ADDR) ? wval0 : wval1;
  end

  // ************************************************************
  // Channel view
  // ************************************************************
  logic [6:0] chen;
  logic wren;
  logic [15:0] chan_view [NUM_CHANNELS];

  for (genvar g = 0; g < NUM_CHANNELS; g++)
  begin : g_chan
    assign chan_view[g] = chen[g] ? chan_result[g] : 16'h0000;
  end

  function automatic logic [15:0] reg_value(input logic [15:0] a);
    logic [15:0] off;
    off = a - CHAN_FIRST_ADDR;
    if (a >= CHAN_FIRST_ADDR && a <= CHAN_LAST_ADDR)
      return chan_view[off[2:0]];
    else if (a == CFG_WREN_ADDR)
      return {15'h0000, wren};
    else if (a == CFG_CHEN_ADDR)
      return {9'h000, chen};
    else
      return 16'h0000;
  endfunction

  // ************************************************************
  // Command machine and reply stream
  // ************************************************************
  reply_kind_t kind;
  reply_kind_t next_kind;
  logic [7:0] exc;
  logic [7:0] next_exc;
  logic [8:0] tx_idx;
  logic [8:0] next_tx_idx;
  logic [8:0] tx_len;
  logic [8:0] next_tx_len;
  logic [15:0] tx_crc;
  logic [15:0] next_tx_crc;
  logic next_tx_valid;
  logic [7:0] next_tx_data;
  logic next_tx_last;
  logic next_wren;
  logic [6:0] next_chen;
  logic next_nv_wr;
  logic [6:0] next_nv_data;
  logic loaded;
  logic next_loaded;

  function automatic logic [7:0] reply_byte(input reply_kind_t k, input logic [8:0] i,
                                            input logic [8:0] len, input logic [7:0] code,
                                            input logic [15:0] crc);
    logic [8:0] d;
    logic [15:0] v;
    d = i - READ_DATA_START;
    v = reg_value(start + {8'h00, d[8:1]});
    if (i == len - 9'h002)
      return crc[7:0];
    else if (i == len - 9'h001)
      return crc[15:8];
    else if (i == 9'h000)
      return frame_buf[IDX_SLAVE];
    else if (k == kind_exc)
      return (i == 9'h001) ? (func | EXC_FLAG) : code;
    else if (k == kind_write)
      return frame_buf[i[7:0]];
    else if (i == 9'h001)
      return func;
    else if (i == 9'h002)
      return {qty[6:0], 1'b0};
    else
      return d[0] ? v[7:0] : v[15:8];
  endfunction

  always_comb
  begin
    next_st = st;
    next_rx_cnt = rx_cnt;
    next_rx_crc = rx_crc;
    next_rx_ovf = rx_ovf;
    next_kind = kind;
    next_exc = exc;
    next_tx_idx = tx_idx;
    next_tx_len = tx_len;
    next_tx_crc = tx_crc;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_tx_last = tx_last;
    next_wren = wren;
    next_chen = chen;
    next_nv_wr = 1'b0;
    next_nv_data = nv_data;
    next_loaded = 1'b1;
    if (!loaded)
      next_chen = nv_chen;
    case (st)
      st_rx:
      begin
        if (rx_valid)
        begin
          next_rx_crc = crc_step(rx_crc, rx_data);
          if (rx_cnt[8])
            next_rx_ovf = 1'b1;
          else
            next_rx_cnt = rx_cnt + 9'h001;
        end
        if (rx_end)
          next_st = st_check;
      end
      st_check:
      begin
        next_st = st_rx;
        next_rx_cnt = 9'h000;
        next_rx_crc = CRC_INIT;
        next_rx_ovf = 1'b0;
        if (good_frame)
        begin
          next_kind = kind_exc;
          next_exc = 8'h00;
          if (busy)
            next_exc = EXC_BUSY;
          else if (!is_read && func != FC_WRITE_MULTI)
            next_exc = EXC_ILLEGAL_FUNCTION;
          else if (is_read)
          begin
            if (rx_cnt != READ_FRAME_LEN || qty == 16'h0000 || qty > READ_MAX_QTY)
              next_exc = EXC_ILLEGAL_VALUE;
            else if (!in_chan && !in_cfg)
              next_exc = EXC_ILLEGAL_ADDRESS;
            else
              next_kind = kind_read;
          end
          else if (qty == 16'h0000 || {8'h00, bcount} != {qty[14:0], 1'b0}
                   || rx_cnt != WRITE_HDR_LEN + {1'b0, bcount})
            next_exc = EXC_ILLEGAL_VALUE;
          else if (!in_cfg)
            next_exc = EXC_ILLEGAL_ADDRESS;
          else if ((hit_wren && wval0 > WREN_MAX_VALUE) || (hit_chen && chen_val > CHEN_MAX_VALUE))
            next_exc = EXC_ILLEGAL_VALUE;
          else if (hit_chen && !wren)
            next_exc = EXC_NAK;
          else
          begin
            next_kind = kind_write;
            if (hit_wren)
              next_wren = wval0[0];
            if (hit_chen)
            begin
              next_chen = chen_val[6:0];
              next_nv_wr = 1'b1;
              next_nv_data = chen_val[6:0];
            end
          end
          case (next_kind)
            kind_read: next_tx_len = READ_REPLY_FIXED + {qty[7:0], 1'b0};
            kind_write: next_tx_len = WRITE_REPLY_LEN;
            default: next_tx_len = EXC_REPLY_LEN;
          endcase
          next_st = st_tx;
          next_tx_idx = 9'h000;
          next_tx_crc = CRC_INIT;
          next_tx_valid = 1'b1;
          next_tx_data = frame_buf[IDX_SLAVE];
          next_tx_last = 1'b0;
        end
      end
      st_tx:
      begin
        if (tx_ready)
        begin
          if (tx_last)
          begin
            next_st = st_rx;
            next_tx_valid = 1'b0;
            next_tx_last = 1'b0;
          end
          else
          begin
            // CRC freezes once its own bytes start going out
            if (tx_idx < tx_len - 9'h002)
              next_tx_crc = crc_step(tx_crc, tx_data);
            next_tx_idx = tx_idx + 9'h001;
            next_tx_data = reply_byte(kind, next_tx_idx, tx_len, exc, next_tx_crc);
            next_tx_last = next_tx_idx == tx_len - 9'h001;
          end
        end
      end
      default:
        next_st = st_rx;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= st_rx;
      rx_cnt <= 9'h000;
      rx_crc <= CRC_INIT;
      rx_ovf <= 1'b0;
      kind <= kind_exc;
      exc <= 8'h00;
      tx_idx <= 9'h000;
      tx_len <= EXC_REPLY_LEN;
      tx_crc <= CRC_INIT;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      wren <= WREN_RESET;
      chen <= CHEN_RESET;
      nv_wr <= 1'b0;
      nv_data <= CHEN_RESET;
      loaded <= 1'b0;
    end
    else
    begin
      st <= next_st;
      rx_cnt <= next_rx_cnt;
      rx_crc <= next_rx_crc;
      rx_ovf <= next_rx_ovf;
      kind <= next_kind;
      exc <= next_exc;
      tx_idx <= next_tx_idx;
      tx_len <= next_tx_len;
      tx_crc <= next_tx_crc;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      tx_last <= next_tx_last;
      wren <= next_wren;
      chen <= next_chen;
      nv_wr <= next_nv_wr;
      nv_data <= next_nv_data;
      loaded <= next_loaded;
    end
  end

  assign chan_enable = chen;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_good_check;
    st == st_check && good_frame;
  endsequence
  sequence s_nak_start;
    st == st_check ##1 st == st_tx && kind == kind_exc && exc == EXC_NAK;
  endsequence

  AST_BUSY_EXC: assert property (@(posedge clk) disable iff (rst)
    s_good_check and busy |=> kind == kind_exc && exc == EXC_BUSY)
    else $error("busy window did not answer exception 06");
  AST_BUSY_END: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) |-> $past(busy_cnt) == BUSY_CYCLES - 1)
    else $error("busy window ended at wrong count");
  AST_ILLEGAL_FUNC: assert property (@(posedge clk) disable iff (rst)
    s_good_check and !busy && !is_read && func != FC_WRITE_MULTI |=> exc == EXC_ILLEGAL_FUNCTION)
    else $error("unknown function not answered with 01");
  AST_EXC_FLAG: assert property (@(posedge clk) disable iff (rst)
    st == st_tx && kind == kind_exc && tx_idx == 9'h001 |-> tx_data == (func | EXC_FLAG))
    else $error("exception function byte lacks top bit");
  AST_WRITE_ECHO: assert property (@(posedge clk) disable iff (rst)
    st == st_tx && kind == kind_write && tx_idx < ECHO_BYTES |-> tx_data == frame_buf[tx_idx[7:0]])
    else $error("preset reply does not echo request");
  AST_NAK_KEEPS: assert property (@(posedge clk) disable iff (rst)
    s_nak_start |-> $stable(chen) && !nv_wr)
    else $error("refused store changed configuration");
  AST_SILENT_DROP: assert property (@(posedge clk) disable iff (rst)
    st == st_check && !good_frame |=> st == st_rx && !tx_valid)
    else $error("bad frame produced a reply");
  AST_READ_COUNT: assert property (@(posedge clk) disable iff (rst)
    st == st_tx && kind == kind_read && tx_idx == 9'h002 |-> tx_data == {qty[6:0], 1'b0})
    else $error("read reply byte count wrong");
  AST_TX_END: assert property (@(posedge clk) disable iff (rst)
    tx_valid && tx_ready && tx_last |-> tx_idx == tx_len - 9'h001 ##1 !tx_valid [*2])
    else $error("reply length or end wrong");
endmodule
`default_nettype wire

/* File: test/modbus_host_model.sv */
// Host computer model: sends RTU request frames and drains reply bytes
`default_nettype none
module modbus_host_model
  import modbus_slave_pkg::*;
(
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] byte_q_t [$];
  byte_q_t reply;
  bit slow = 1'b0;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    tx_ready = 1'b1;
  end
  // ************************************************************
  // Frame check sequence
  // ************************************************************
  function automatic logic [15:0] crc16(input byte_q_t q);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  // ************************************************************
  // Request and reply
  // ************************************************************
  // Fields arrive in the order given by the caller, then the CRC low byte first
  task automatic send(input byte_q_t f);
    logic [15:0] c;
    c = crc16(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i])
    begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = f[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    // Released data must not keep the last byte, or a stale sample looks valid
    rx_data = ~rx_data;
    rx_end = 1'b1;
    @(negedge clk);
    rx_end = 1'b0;
  endtask
  // Slow mode stalls ready two cycles in four to exercise holding of tx_data
  task automatic receive(output bit ok);
    int n;
    reply.delete();
    ok = 1'b0;
    for (n = 0; n < 400 && !ok; n++)
    begin
      @(negedge clk);
      tx_ready = slow ? n[1] : 1'b1;
      #1;
      if (tx_valid === 1'b1 && tx_ready)
      begin
        reply.push_back(tx_data);
        ok = (tx_last === 1'b1);
      end
    end
    @(negedge clk);
    tx_ready = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: test/modbus_slave_tb.sv */
// Self-checking testbench for the Modbus RTU slave command handler
`default_nettype none
module modbus_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import modbus_slave_pkg::*;
  typedef logic [7:0] byte_q_t [$];
  logic clk, rst, rx_valid, rx_end, tx_ready, tx_valid, tx_last, nv_wr, busy;
  logic [7:0] rx_data, tx_data;
  logic [6:0] nv_data, chan_enable;
  // Stored mask, fed back as the power-up value the way the memory would
  logic [6:0] nv_last = 7'h7f;
  logic [15:0] chan [NUM_CHANNELS];
  int num_errors = 0;
  int total_checks = 0;
  int nv_count = 0;
  int cycles = 0;
  modbus_slave #(.BUSY_CYCLES(50)) DUT (.clk(clk), .rst(rst), .slave_addr(8'h11), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .tx_ready(tx_ready), .chan_result(chan), .nv_chen(nv_last),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .nv_wr(nv_wr), .nv_data(nv_data),
    .chan_enable(chan_enable), .busy(busy));
  modbus_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge clk)
  begin
    cycles++;
    if (nv_wr === 1'b1)
    begin
      nv_count++;
      nv_last = nv_data;
    end
    if (cycles == 20000)
    begin
      num_errors++;
      test_done();
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic run(input byte_q_t req, input byte_q_t exp);
    bit ok;
    logic [15:0] c;
    c = host.crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    host.send(req);
    host.receive(ok);
    chk("reply_done", 16'h0001, 16'(ok));
    chk("reply_length", 16'(exp.size()), 16'(host.reply.size()));
    foreach (exp[i])
      if (i < host.reply.size())
        chk("reply_byte", {8'h00, exp[i]}, {8'h00, host.reply[i]});
  endtask
  task automatic exc(input byte_q_t req, input logic [7:0] code);
    run(req, '{8'h11, req[1] | EXC_FLAG, code});
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_busy();
    int n;
    chk("busy", 16'h0001, {15'h0000, busy});
    chk("chan_enable", 16'h007f, {9'h000, chan_enable});
    exc('{8'h11, 8'h03, 8'h9c, 8'h71, 8'h00, 8'h07}, EXC_BUSY);
    for (n = 0; n < 100 && busy !== 1'b0; n++)
      @(negedge clk);
    chk("busy", 16'h0000, {15'h0000, busy});
    $display("test_busy done");
  endtask
  task automatic test_read();
    byte_q_t exp;
    logic [7:0] fcs [2];
    fcs = '{FC_READ_HOLD, FC_READ_INPUT};
    foreach (fcs[k])
    begin
      exp = '{8'h11, fcs[k], 8'h0e};
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
        exp.push_back(chan[i][15:8]);
        exp.push_back(chan[i][7:0]);
      end
      host.slow = (k == 1);
      run('{8'h11, fcs[k], 8'h9c, 8'h71, 8'h00, 8'h07}, exp);
    end
    host.slow = 1'b0;
    $display("test_read done");
  endtask
  task automatic test_exceptions();
    byte_q_t reqs [6];
    logic [7:0] codes [6];
    bit ok;
    reqs[0] = '{8'h11, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00};
    reqs[1] = '{8'h11, 8'h03, 8'h9c, 8'h78, 8'h00, 8'h01};
    reqs[2] = '{8'h11, 8'h04, 8'h9c, 8'h71, 8'h00, 8'h00};
    reqs[3] = '{8'h11, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00};
    reqs[4] = '{8'h11, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00, 8'h80};
    reqs[5] = '{8'h11, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
    codes = '{EXC_ILLEGAL_FUNCTION, EXC_ILLEGAL_ADDRESS, EXC_ILLEGAL_VALUE, EXC_ILLEGAL_VALUE, EXC_ILLEGAL_VALUE,
      EXC_ILLEGAL_ADDRESS};
    foreach (reqs[i])
      exc(reqs[i], codes[i]);
    // A frame for another slave must pass without any reply
    host.send('{8'h22, 8'h03, 8'h9c, 8'h71, 8'h00, 8'h01});
    host.receive(ok);
    chk("dropped_done", 16'h0000, 16'(ok));
    chk("dropped_length", 16'h0000, 16'(host.reply.size()));
    $display("test_exceptions done");
  endtask
  task automatic test_nv();
    int n0;
    n0 = nv_count;
    exc('{8'h11, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00, 8'h05}, EXC_NAK);
    chk("nv_wr_count", 16'(n0), 16'(nv_count));
    chk("chan_enable", 16'h007f, {9'h000, chan_enable});
    run('{8'h11, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
      '{8'h11, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01});
    run('{8'h11, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00, 8'h05},
      '{8'h11, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01});
    chk("nv_wr_count", 16'(n0 + 1), 16'(nv_count));
    chk("nv_data", 16'h0005, {9'h000, nv_last});
    chk("chan_enable", 16'h0005, {9'h000, chan_enable});
    // Channels 1 and 3 onward are now disabled and must read as zero
    run('{8'h11, 8'h03, 8'h9c, 8'h71, 8'h00, 8'h03},
      '{8'h11, 8'h03, 8'h06, chan[0][15:8], chan[0][7:0], 8'h00, 8'h00, chan[2][15:8], chan[2][7:0]});
    $display("test_nv done");
  endtask
  // Second reset: stored mask must come back, write enable must not
  task automatic test_reset();
    int n0;
    n0 = nv_count;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("busy", 16'h0001, {15'h0000, busy});
    chk("chan_enable", 16'h0005, {9'h000, chan_enable});
    exc('{8'h11, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02}, EXC_BUSY);
    for (int k = 0; k < 100 && busy !== 1'b0; k++)
      @(negedge clk);
    chk("busy", 16'h0000, {15'h0000, busy});
    exc('{8'h11, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h03}, EXC_NAK);
    run('{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02},
      '{8'h11, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h05});
    chk("nv_wr_count", 16'(n0), 16'(nv_count));
    $display("test_reset done");
  endtask
  initial
  begin
    rst = 1'b1;
    for (int i = 0; i < NUM_CHANNELS; i++)
      chan[i] = 16'(i) * 16'h1111;
    chan[6] = 16'hffff;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    test_busy();
    test_read();
    test_exceptions();
    test_nv();
    test_reset();
    test_done();
  end
endmodule
`default_nettype wire
